// file: ech_device.sv
// Device end: decodes terminated commands and performs execution actions.
// Assumes strap pins are asynchronous and are synchronised here.
`include "ech_params.svh"
module ech_device #(
  parameter int unsigned RESET_DELAY_CYCLES = `ECH_SOFT_RESET_CYCLES,
  parameter int unsigned TIMEOUT_UNIT_CYCLES = `ECH_CMD_TIMEOUT_UNIT_MS * (`ECH_CLK_HZ / 1000)
) (
  input wire logic mclk,
  input wire logic reset_n,
  ech_link_if.device link,
  input wire logic cmd_mode, // Command mode entered by the outer parser
  output logic cmd_mode_exit, // Pulse when command mode ends
  output logic [3:0] active_rate, // Serial rate in use
  output logic [3:0] pending_rate, // Queued serial rate
  output logic associated, // Associated with an access point
  output logic [7:0] ssid_len, // Stored SSID length, zero means null
  output logic scan_enable, // Active scan permitted
  output logic nv_write, // Pulse: store parameters in nonvolatile memory
  output logic [3:0] nv_rate, // Persisted rate
  output logic soft_reset, // Pulse: software reset
  output logic boot_select, // Bootloader runs instead of application
  output logic fw_strobe, // Accepted firmware byte strobe
  output logic [7:0] fw_byte // Accepted firmware byte
);
  import ech_pkg::*;

  // Refuse counts that the reset delay and timeout unit counters cannot serve
  if (RESET_DELAY_CYCLES < 1 || TIMEOUT_UNIT_CYCLES < 1) begin : gen_bad_counts
    $error("ech_device: counts must be at least one");
  end

  // Strap synchronisers, two flops each
  logic [2:0] strap_meta;
  logic [2:0] strap_sync;
  logic [1:0] strap_age; // Edges since release, saturating at three
  ech_op_type held_op; // Last command seen, waiting for terminator
  logic [3:0] held_arg;
  logic [31:0] reset_count; // Delay before software reset
  logic reset_armed;
  logic [31:0] unit_count; // Inactivity timer, 100 ms units
  logic [15:0] idle_units;
  logic in_cmd;

  // Decode: only a terminator fires the held command
  wire term_seen = link.char_valid && link.char_data == `ECH_TERMINATOR;
  wire op_code_seen = link.char_valid && !term_seen;
  wire fire = term_seen && held_op != ECH_OP_NONE;
  wire do_apply_cmd = fire && held_op == ECH_OP_APPLY;
  wire do_api_apply = link.api_valid && link.api_type == `ECH_API_APPLY_FRAME;
  wire timeout_hit = in_cmd && idle_units >= `ECH_CMD_TIMEOUT_DEFAULT;
  wire do_exit = (fire && held_op == ECH_OP_EXIT_CMD) || timeout_hit;
  wire do_apply = do_apply_cmd || do_api_apply || do_exit;
  wire do_net_reset = fire && (held_op == ECH_OP_NET_RESET || held_op == ECH_OP_NET_RESET_ALIAS);
  wire do_restore = fire && held_op == ECH_OP_RESTORE;
  wire do_persist = fire && held_op == ECH_OP_PERSIST;
  wire do_soft = fire && held_op == ECH_OP_SOFT_RESET;
  wire do_rate = fire && held_op == ECH_OP_SET_RATE;
  wire fw_ok = link.fw_valid && link.on_uart;
  wire [3:0] next_pending_rate = do_restore ? `ECH_RATE_RESET : (do_rate ? held_arg : pending_rate);
  wire strap_boot = !strap_sync[2] && !strap_sync[1] && strap_sync[0];
  // Sync output then holds the pin levels of the last reset edge
  wire strap_capture = strap_age == `ECH_STRAP_SETTLE;

  // Strap synchronisers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      strap_meta <= 3'h0;
      strap_sync <= 3'h0;
    end else begin
      strap_meta <= {link.din_pin, link.dtr_pin, link.rts_pin};
      strap_sync <= strap_meta;
    end
  end

  // Straps caught once after release; no firmware involvement at all
  // Waiting two edges lets the levels held at reset cross both flops
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      strap_age <= 2'h0;
      boot_select <= 1'b0;
    end else if (strap_age != 2'h3) begin
      strap_age <= strap_age + 2'h1;
      if (strap_capture) begin
        boot_select <= strap_boot;
      end
    end
  end

  // Hold the command name until the terminator arrives
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      held_op <= ECH_OP_NONE;
      held_arg <= 4'h0;
    end else if (term_seen) begin
      held_op <= ECH_OP_NONE;
    end else if (op_code_seen) begin
      held_op <= ech_op_type'(link.char_data[3:0]);
      held_arg <= link.char_arg;
    end
  end

  // Rate: queued first, active only on apply
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pending_rate <= `ECH_RATE_RESET;
      active_rate <= `ECH_RATE_RESET;
    end else begin
      pending_rate <= next_pending_rate;
      if (do_apply) begin
        active_rate <= next_pending_rate;
      end
    end
  end

  // Network state; scan opened by network reset
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      associated <= 1'b1;
      ssid_len <= `ECH_SSID_LEN_RESET;
      scan_enable <= 1'b0;
    end else if (do_net_reset) begin
      associated <= 1'b0;
      ssid_len <= `ECH_DEFAULT_SSID_LEN;
      scan_enable <= 1'b1;
    end else if (do_restore) begin
      ssid_len <= `ECH_DEFAULT_SSID_LEN;
    end
  end

  // Persist current values, acted on at once
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      nv_write <= 1'b0;
      nv_rate <= `ECH_RATE_RESET;
    end else begin
      nv_write <= do_persist;
      if (do_persist) begin
        nv_rate <= active_rate;
      end
    end
  end

  // Soft reset delay counter; reset fires after the count runs out
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reset_armed <= 1'b0;
      reset_count <= 32'h0;
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= 1'b0;
      if (do_soft) begin
        reset_armed <= 1'b1;
        reset_count <= 32'(RESET_DELAY_CYCLES - 1);
      end else if (reset_armed) begin
        if (reset_count == 32'h0) begin
          reset_armed <= 1'b0;
          soft_reset <= 1'b1;
        end else begin
          reset_count <= reset_count - 32'h1;
        end
      end
    end
  end

  // Command mode inactivity timer in 100 ms units
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      in_cmd <= 1'b0;
      unit_count <= 32'h0;
      idle_units <= 16'h0;
      cmd_mode_exit <= 1'b0;
    end else begin
      cmd_mode_exit <= do_exit && in_cmd;
      if (do_exit) begin
        in_cmd <= 1'b0;
      end else if (cmd_mode) begin
        in_cmd <= 1'b1;
      end
      if (!in_cmd || fire) begin
        unit_count <= 32'h0;
        idle_units <= 16'h0;
      end else if (unit_count == 32'(TIMEOUT_UNIT_CYCLES - 1)) begin
        unit_count <= 32'h0;
        idle_units <= idle_units + 16'h1;
      end else begin
        unit_count <= unit_count + 32'h1;
      end
    end
  end

  // Answer OK one cycle after each accepted command; firmware bytes pass UART only
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      link.rsp_valid <= 1'b0;
      link.rsp <= ECH_RSP_NONE;
      fw_strobe <= 1'b0;
      fw_byte <= 8'h00;
    end else begin
      link.rsp_valid <= fire;
      link.rsp <= fire ? ECH_RSP_OK : ECH_RSP_NONE;
      fw_strobe <= fw_ok;
      if (fw_ok) begin
        fw_byte <= link.fw_data;
      end
    end
  end
endmodule

// file: ech_params.svh
// Constants for the execution command handler (both ends).
// Assumes a 10 MHz mclk; included by bare name from the modules only, not the package.
`ifndef ECH_PARAMS_SVH
`define ECH_PARAMS_SVH
`define ECH_CLK_HZ 10000000
`define ECH_SOFT_RESET_DELAY_MS 2000
`define ECH_SOFT_RESET_CYCLES ((`ECH_SOFT_RESET_DELAY_MS) * (`ECH_CLK_HZ / 1000))
`define ECH_CMD_TIMEOUT_UNIT_MS 100
`define ECH_CMD_TIMEOUT_DEFAULT 16'h0064
`define ECH_API_APPLY_FRAME 8'h08
`define ECH_TERMINATOR 8'h0D
`define ECH_RATE_RESET 4'h3
`define ECH_DEFAULT_SSID_LEN 8'h00
`define ECH_SSID_LEN_RESET 8'h08
`define ECH_STRAP_SETTLE 2'h2
`endif

// file: ech_pkg.sv
// Types shared by both ends of the execution command handler.
// Assumes ech_params.svh for numeric constants.
package ech_pkg;
  // Command codes carried from host to device
  typedef enum logic [3:0] {
    ECH_OP_NONE = 4'h0,
    ECH_OP_APPLY = 4'h1,
    ECH_OP_PERSIST = 4'h2,
    ECH_OP_RESTORE = 4'h3,
    ECH_OP_SOFT_RESET = 4'h4,
    ECH_OP_NET_RESET = 4'h5,
    ECH_OP_NET_RESET_ALIAS = 4'h6,
    ECH_OP_EXIT_CMD = 4'h7,
    ECH_OP_SET_RATE = 4'h8,
    ECH_OP_SCAN = 4'h9
  } ech_op_type;
  // Device responses
  typedef enum logic [1:0] {
    ECH_RSP_NONE = 2'h0,
    ECH_RSP_OK = 2'h1,
    ECH_RSP_ERROR = 2'h2
  } ech_rsp_type;
endpackage

// file: ech_link_if.sv
// Link between host controller and the command handler on the module.
// Assumes a shared mclk; frames are character-per-cycle strobes.
interface ech_link_if (
  input wire logic mclk
);
  import ech_pkg::*;
  logic char_valid; // Host strobes one character
  logic [7:0] char_data; // Command character
  logic [3:0] char_arg; // Argument nibble (rate value)
  logic api_valid; // Host strobes an API frame type
  logic [7:0] api_type; // API frame type
  logic on_uart; // Host uses the asynchronous serial port
  logic fw_valid; // Firmware image byte strobe
  logic [7:0] fw_data; // Firmware image byte
  logic rsp_valid; // Device answer strobe
  ech_rsp_type rsp; // Device answer code
  logic din_pin; // Strap: serial data in (driven by host)
  logic dtr_pin; // Strap: DTR
  logic rts_pin; // Strap: RTS
  modport host (output char_valid, char_data, char_arg, api_valid, api_type, on_uart, fw_valid, fw_data,
    din_pin, dtr_pin, rts_pin, input rsp_valid, rsp);
  modport device (input char_valid, char_data, char_arg, api_valid, api_type, on_uart, fw_valid, fw_data,
    din_pin, dtr_pin, rts_pin, output rsp_valid, rsp);
endinterface

// file: ech_host.sv
// Host end: issues one command at a time and respects the persist wait.
// Assumes the device answers OK over the link; straps driven while in reset.
`include "ech_params.svh"
module ech_host (
  input wire logic mclk,
  input wire logic reset_n,
  ech_link_if.host link,
  input wire logic cmd_req, // Request to send one command
  input wire ech_pkg::ech_op_type cmd_op, // Command to send
  input wire logic [3:0] cmd_arg, // Argument
  input wire logic want_boot, // Drive bootloader straps
  input wire logic use_uart, // Host port selection
  input wire logic fw_req, // Firmware byte request
  input wire logic [7:0] fw_in, // Firmware byte
  input wire logic api_req, // Request one apply frame
  output logic cmd_busy, // Command in flight or waiting for OK
  output logic cmd_done, // Pulse on OK
  output logic fw_refused // Pulse when firmware requested off UART
);
  import ech_pkg::*;

  // Host sequencer
  typedef enum logic [2:0] {
    ECH_H_IDLE = 3'b001,
    ECH_H_TERM = 3'b010,
    ECH_H_WAIT = 3'b100
  } ech_hstate_type;
  ech_hstate_type state;
  logic persist_wait; // Persist sent: no characters until OK

  // Character stream and apply frames
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state <= ECH_H_IDLE;
      persist_wait <= 1'b0;
      link.char_valid <= 1'b0;
      link.char_data <= 8'h00;
      link.char_arg <= 4'h0;
      link.api_valid <= 1'b0;
      link.api_type <= 8'h00;
      cmd_busy <= 1'b0;
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      link.char_valid <= 1'b0;
      // Apply frame needs no answer, so it bypasses the sequencer
      link.api_valid <= api_req;
      link.api_type <= `ECH_API_APPLY_FRAME;
      unique case (state)
        ECH_H_IDLE: begin
          if (cmd_req && !persist_wait) begin
            link.char_valid <= 1'b1;
            link.char_data <= {4'h0, cmd_op};
            link.char_arg <= cmd_arg;
            persist_wait <= cmd_op == ECH_OP_PERSIST;
            cmd_busy <= 1'b1;
            state <= ECH_H_TERM;
          end
        end
        ECH_H_TERM: begin
          link.char_valid <= 1'b1;
          link.char_data <= `ECH_TERMINATOR;
          state <= ECH_H_WAIT;
        end
        ECH_H_WAIT: begin
          // No character is sent until OK, as persist demands
          if (link.rsp_valid && link.rsp == ECH_RSP_OK) begin
            persist_wait <= 1'b0;
            cmd_busy <= 1'b0;
            cmd_done <= 1'b1;
            state <= ECH_H_IDLE;
          end
        end
      endcase
    end
  end

  // Straps held during reset, released to idle levels afterwards
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      link.din_pin <= !want_boot;
      link.dtr_pin <= !want_boot;
      link.rts_pin <= want_boot;
    end else begin
      link.din_pin <= 1'b1;
      link.dtr_pin <= 1'b1;
      link.rts_pin <= 1'b0;
    end
  end

  // Firmware only over UART
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      link.on_uart <= 1'b1;
      link.fw_valid <= 1'b0;
      link.fw_data <= 8'h00;
      fw_refused <= 1'b0;
    end else begin
      link.on_uart <= use_uart;
      link.fw_valid <= fw_req && use_uart;
      link.fw_data <= fw_in;
      fw_refused <= fw_req && !use_uart;
    end
  end
endmodule

// file: ech_monitor.sv
// Checker for the host to device command link.
// Assumes the bench wires it beside the link interface; one clock domain.
`include "ech_params.svh"
module ech_monitor (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic char_valid,
  input wire logic [7:0] char_data,
  input wire logic on_uart,
  input wire logic fw_valid,
  input wire logic rsp_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [3:0] held; // Op waiting for its terminator
  wire term = char_valid && (char_data == `ECH_TERMINATOR); // Terminator char
  wire op_char = char_valid && (char_data != `ECH_TERMINATOR); // Op char
  // Held op copy; a terminator consumes it so a lone one stays silent
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      held <= 4'h0;
    end else if (char_valid) begin
      held <= term ? 4'h0 : char_data[3:0];
    end
  end
  sequence s_op_term;
    op_char ##1 term;
  endsequence
  sequence s_answer;
    rsp_valid ##1 !rsp_valid;
  endsequence
  a_op_then_term: assert property (op_char |=> term) else $error("op char not terminated");
  a_cmd_walk: assert property (s_op_term |=> s_answer) else $error("command not answered");
  a_term_answers: assert property (term && held != 4'h0 |=> rsp_valid) else $error("no answer");
  a_rsp_cause: assert property (rsp_valid |-> $past(term) && $past(held) != 4'h0)
    else $error("answer without command");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid) else $error("answer too long");
  a_single_op: assert property (op_char |=> !op_char) else $error("two op chars");
  a_wait_for_ok: assert property (term |=> !char_valid [*2]) else $error("char before OK");
  a_fw_uart_only: assert property (fw_valid |-> on_uart) else $error("firmware off uart");
endmodule

// file: execution_command_handler_tb.sv
// Bench joining host and device ends over the link interface.
// Assumes short delay parameters; drives host user side and cmd_mode.
module execution_command_handler_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ech_pkg::*;
  localparam int DLY = 10; // Short soft reset delay
  typedef struct {ech_op_type op; logic [3:0] arg, act, pen; logic asc, scn; logic [7:0] sid;} ech_row_type;
  logic mclk = 0, reset_n = 0, cmd_req = 0, want_boot = 0, use_uart = 1, fw_req = 0, cmd_mode = 1, api_req = 0;
  logic nv_seen; // Store pulse seen during the last command
  ech_op_type cmd_op = ECH_OP_NONE;
  logic [3:0] cmd_arg = 4'h0;
  logic [7:0] fw_in = 8'h00;
  logic cmd_busy, cmd_done, fw_refused, mode_exit, assoc, scan, nv_wr, srst, boot, fw_stb;
  logic [3:0] act, pen, nv_rate;
  logic [7:0] ssid, fw_byte;
  int fails = 0, samples_checked = 0, t_rsp, t_sr, i;
  // Rows: command, argument, then expected rates, association, scan, ssid
  ech_row_type rows [8] = '{
    '{ECH_OP_SET_RATE, 4'h5, 4'h3, 4'h5, 1, 0, 8'h08}, '{ECH_OP_APPLY, 4'h0, 4'h5, 4'h5, 1, 0, 8'h08},
    '{ECH_OP_SET_RATE, 4'h7, 4'h5, 4'h7, 1, 0, 8'h08}, '{ECH_OP_EXIT_CMD, 4'h0, 4'h7, 4'h7, 1, 0, 8'h08},
    '{ECH_OP_PERSIST, 4'h0, 4'h7, 4'h7, 1, 0, 8'h08}, '{ECH_OP_RESTORE, 4'h0, 4'h7, 4'h3, 1, 0, 8'h00},
    '{ECH_OP_NET_RESET, 4'h0, 4'h7, 4'h3, 0, 1, 8'h00}, '{ECH_OP_SCAN, 4'h0, 4'h7, 4'h3, 0, 1, 8'h00}};
  ech_link_if ech_link_if_i (.mclk(mclk));
  ech_host ech_host_i (.mclk(mclk), .reset_n(reset_n), .link(ech_link_if_i.host), .cmd_req(cmd_req),
    .cmd_op(cmd_op), .cmd_arg(cmd_arg), .want_boot(want_boot), .use_uart(use_uart), .fw_req(fw_req),
    .fw_in(fw_in), .api_req(api_req), .cmd_busy(cmd_busy), .cmd_done(cmd_done), .fw_refused(fw_refused));
  ech_device #(.RESET_DELAY_CYCLES(DLY), .TIMEOUT_UNIT_CYCLES(4)) ech_device_i (.mclk(mclk),
    .reset_n(reset_n), .link(ech_link_if_i.device), .cmd_mode(cmd_mode), .cmd_mode_exit(mode_exit),
    .active_rate(act), .pending_rate(pen), .associated(assoc), .ssid_len(ssid), .scan_enable(scan),
    .nv_write(nv_wr), .nv_rate(nv_rate), .soft_reset(srst), .boot_select(boot), .fw_strobe(fw_stb),
    .fw_byte(fw_byte));
  ech_monitor ech_monitor_i (.mclk(mclk), .reset_n(reset_n), .char_valid(ech_link_if_i.char_valid),
    .char_data(ech_link_if_i.char_data), .on_uart(ech_link_if_i.on_uart), .fw_valid(ech_link_if_i.fw_valid),
    .rsp_valid(ech_link_if_i.rsp_valid));
  // Free running 10 MHz clock
  initial begin
    forever #50 mclk = ~mclk;
  end
  // Compare one value and count it
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // Counts, verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // One edge, then the usual small drive delay
  task automatic step();
    @(posedge mclk);
    #5;
  endtask
  // Synchronous reset held two cycles
  task automatic do_reset();
    reset_n = 0;
    repeat (2) step();
    reset_n = 1;
  endtask
  // Issue one command and wait for its OK, bounded
  task automatic send(input ech_op_type op, input logic [3:0] arg);
    cmd_req = 1;
    cmd_op = op;
    cmd_arg = arg;
    step();
    cmd_req = 0;
    check("cmd_busy", cmd_busy, 1);
    nv_seen = 0;
    for (i = 0; i < 20 && cmd_done !== 1'b1; i++) begin
      step();
      if (nv_wr === 1'b1) nv_seen = 1;
    end
    if (i == 20) begin
      check("cmd_done", 0, 1);
      results();
    end
    check("cmd_idle", cmd_busy, 0);
  endtask
  initial begin
    do_reset();
    check("reset rate", {act, pen}, 8'h33);
    check("reset assoc", {assoc, scan, boot, ssid}, 11'h408);
    foreach (rows[r]) begin
      send(rows[r].op, rows[r].arg);
      check("rates", {act, pen}, {rows[r].act, rows[r].pen});
      check("net", {assoc, scan, ssid}, {rows[r].asc, rows[r].scn, rows[r].sid});
      if (rows[r].op == ECH_OP_PERSIST) check("nv_rate", nv_rate, 4'h7);
      check("nv_write", nv_seen, rows[r].op == ECH_OP_PERSIST);
    end
    // Soft reset: OK first, restart pulse DLY cycles after the answer
    t_rsp = -1;
    t_sr = -1;
    cmd_req = 1;
    cmd_op = ECH_OP_SOFT_RESET;
    for (int c = 0; c < 40; c++) begin
      step();
      cmd_req = 0;
      if (ech_link_if_i.rsp_valid === 1'b1) t_rsp = c;
      if (srst === 1'b1) t_sr = c;
    end
    check("soft reset gap", t_sr - t_rsp, DLY);
    // Inactivity timeout leaves command mode and applies the queued rate
    cmd_mode = 0;
    step();
    cmd_mode = 1;
    send(ECH_OP_SET_RATE, 4'h9);
    check("queued", act, 4'h7);
    for (i = 0; i < 600 && mode_exit !== 1'b1; i++) step();
    if (i == 600) begin
      check("mode_exit", 0, 1);
      results();
    end
    step();
    check("timeout apply", act, 4'h9);
    // Apply frame from the host moves a newly queued rate
    send(ECH_OP_SET_RATE, 4'h2);
    api_req = 1;
    step();
    api_req = 0;
    check("api queued", act, 4'h9);
    step();
    check("api apply", act, 4'h2);
    // Firmware byte over UART passes, off UART refused
    fw_in = 8'hA5;
    fw_req = 1;
    step();
    fw_req = 0;
    for (i = 0; i < 10 && fw_stb !== 1'b1; i++) step();
    if (i == 10) begin
      check("fw_strobe", 0, 1);
      results();
    end
    check("fw byte", {fw_stb, fw_byte}, 9'h1A5);
    use_uart = 0;
    fw_req = 1;
    step();
    fw_req = 0;
    t_sr = 0;
    for (int c = 0; c < 10; c++) begin
      if (fw_refused === 1'b1) t_sr |= 1;
      if (fw_stb === 1'b1) t_sr |= 2;
      step();
    end
    check("fw refused", t_sr, 1);
    use_uart = 1;
    // Alias does the same as network reset from a fresh state
    do_reset();
    send(ECH_OP_NET_RESET_ALIAS, 4'h0);
    check("alias", {assoc, scan, ssid}, 10'h100);
    // Strapped pins through reset pick the bootloader
    want_boot = 1;
    do_reset();
    repeat (6) step();
    check("boot", boot, 1);
    results();
  end
endmodule
